// *** rilc_map.vh ***
`ifndef RILC_MAP_VH
`define RILC_MAP_VH
// Operation codes and service action
`define RILC_OP_REPORT_ID 8'ha3
`define RILC_SA_REPORT_ID 5'h05
`define RILC_OP_REPORT_LUNS 8'ha0
// Command block byte positions
`define RILC_CDB_OP 4'h0
`define RILC_CDB_SA 4'h1
`define RILC_CDB_LUN_HI 4'h4
`define RILC_CDB_LUN_LO 4'h5
`define RILC_CDB_ALLOC0 4'h6
`define RILC_CDB_ALLOC1 4'h7
`define RILC_CDB_ALLOC2 4'h8
`define RILC_CDB_ALLOC3 4'h9
`define RILC_CDB_LAST 4'hb
// Parameter data layout
`define RILC_ID_HDR_BYTES 32'h00000004
`define RILC_LUN_LIST_LEN 32'h00000008
`define RILC_LUN_MIN_ALLOC 32'h00000010
`define RILC_LUN_TOTAL 32'h00000010
// Status and sense
`define RILC_ST_GOOD 8'h00
`define RILC_ST_CHECK 8'h02
`define RILC_SK_NONE 4'h0
`define RILC_SK_NOT_READY 4'h2
`define RILC_SK_ILLEGAL 4'h5
`define RILC_ASC_INV_CDB 8'h24
`define RILC_ASC_NOT_READY 8'h04
`define RILC_ASCQ_NONE 8'h00
`define RILC_ASCQ_NOT_READY 8'h00
`endif

// *** rilc_cdb_capture.v ***
`timescale 1ns/100ps
`include "rilc_map.vh"
module rilc_cdb_capture (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Command byte stream
    input wire cdb_valid,
    input wire [7:0] cdb_byte,
    input wire cdb_last,
    // Captured fields
    output reg cdb_done,
    output reg [7:0] cdb_opcode,
    output reg [4:0] cdb_sa,
    output reg [15:0] cdb_lun,
    output reg [31:0] cdb_alloc
);
    reg [3:0] idx_r;
    // =========================================
    // Field capture
    always @(posedge clk) begin
        if (!rst_b) begin
            idx_r <= 4'h0;
            cdb_done <= 1'b0;
            cdb_opcode <= 8'h00;
            cdb_sa <= 5'h00;
            cdb_lun <= 16'h0000;
            cdb_alloc <= 32'h00000000;
        end else begin
            cdb_done <= 1'b0;
            if (cdb_valid) begin
                case (idx_r)
                    `RILC_CDB_OP: cdb_opcode <= cdb_byte;
                    `RILC_CDB_SA: cdb_sa <= cdb_byte[4:0];
                    `RILC_CDB_LUN_HI: cdb_lun[15:8] <= cdb_byte;
                    `RILC_CDB_LUN_LO: cdb_lun[7:0] <= cdb_byte;
                    `RILC_CDB_ALLOC0: cdb_alloc[31:24] <= cdb_byte;
                    `RILC_CDB_ALLOC1: cdb_alloc[23:16] <= cdb_byte;
                    `RILC_CDB_ALLOC2: cdb_alloc[15:8] <= cdb_byte;
                    `RILC_CDB_ALLOC3: cdb_alloc[7:0] <= cdb_byte;
                    default: ;
                endcase
                // Last marker resyncs a short or long block
                if (cdb_last || idx_r == `RILC_CDB_LAST) begin
                    idx_r <= 4'h0;
                    cdb_done <= 1'b1;
                end else begin
                    idx_r <= idx_r + 4'h1;
                end
            end
        end
    end
endmodule

// *** rilc_id_store.v ***
`timescale 1ns/100ps
`include "rilc_map.vh"
module rilc_id_store #(
    parameter ID_MAX = 64,
    parameter AW = 6
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Load from a completed set-identifier command
    input wire ld_valid,
    input wire [AW-1:0] ld_addr,
    input wire [7:0] ld_byte,
    input wire ld_commit,
    input wire [31:0] ld_len,
    // Read port
    input wire [AW-1:0] rd_addr,
    output reg [7:0] rd_byte,
    output reg [31:0] id_len
);
    reg [7:0] mem_r [0:ID_MAX-1];
    integer i;
    // =========================================
    // Storage, not cleared by reset so the value persists
    always @(posedge clk) begin
        if (ld_valid)
            mem_r[ld_addr] <= ld_byte; // RL7
        rd_byte <= mem_r[rd_addr];
    end
    // Length alone resets to zero, changed only by a commit
    always @(posedge clk) begin
        if (!rst_b)
            id_len <= 32'h00000000; // RL6
        else if (ld_commit)
            id_len <= ld_len; // RL6
    end
endmodule

// *** rilc_report_cmds.v ***
`timescale 1ns/100ps
`include "rilc_map.vh"
// Notes on behaviour
// RL1: Opcode a3 with service action 05 returns the device identifier data.
// RL2: Nonzero logical unit field in bytes 4-5 ends with illegal request.
// RL3: Allocation length in bytes 6-9 truncates identifier data without error.
// RL4: Identifier data is four-byte big-endian length then identifier bytes.
// RL5: Length field carries full identifier length even when data is truncated.
// RL6: Identifier length is zero until a successful set-identifier command.
// RL7: Identifier value keeps the last set value through resets; the bytes persist but reset zeroes the length until a commit.
// RL8: Every initiator on every port gets the same identifier.
// RL9: Store not ready ends identifier report at once with not ready.
// RL10: Opcode a0 returns the logical unit list, truncated to allocation length.
// RL11: Logical unit listing runs regardless of any reservation.
// RL12: Listing allocation length below 16 ends with illegal request.
// RL13: Short allocation sends as many whole entries as fit, no error.
// RL14: List is length 8, four reserved bytes, one zero eight-byte entry.
// RL15: List goes out in the data phase after command acceptance.
module rilc_report_cmds #(
    parameter ID_MAX = 64,
    parameter AW = 6
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Command block bytes from the transport
    input wire cdb_valid,
    input wire [7:0] cdb_byte,
    input wire cdb_last,
    // Reservation conflict flag, ignored here
    input wire rsv_conflict,
    // Nonvolatile store state, from a pin
    input wire nv_ready_pin,
    // Identifier load from the set-identifier path
    input wire ld_valid,
    input wire [AW-1:0] ld_addr,
    input wire [7:0] ld_byte,
    input wire ld_commit,
    input wire [31:0] ld_len,
    // Data-in stream to the initiator
    output reg din_valid,
    output reg [7:0] din_byte,
    output reg din_last,
    input wire din_ready,
    // Completion
    output reg done_r,
    output reg [7:0] status_r,
    output reg [3:0] sense_key_r,
    output reg [7:0] asc_r,
    output reg [7:0] ascq_r
);
    localparam S_IDLE = 4'b0001;
    localparam S_PREP = 4'b0010;
    localparam S_SEND = 4'b0100;
    localparam S_DONE = 4'b1000;
    localparam [1:0] K_NONE = 2'b00;
    localparam [1:0] K_ID = 2'b01;
    localparam [1:0] K_LUNS = 2'b10;
    localparam [31:0] LUN_LIST_LEN = `RILC_LUN_LIST_LEN;

    wire cdb_done;
    wire [7:0] cdb_op;
    wire [4:0] cdb_sa;
    wire [15:0] cdb_lun;
    wire [31:0] cdb_alloc;
    wire [7:0] id_rd_byte;
    wire [31:0] id_len;
    reg [3:0] state_r;
    reg is_id_r;
    reg [31:0] total_r;
    reg [31:0] cnt_r;
    reg nv_meta_r;
    reg nv_sync_r;
    // Next values of the sequencer and completion registers
    reg [3:0] state_nxt;
    reg is_id_nxt;
    reg [31:0] total_nxt;
    reg [31:0] cnt_nxt;
    reg din_valid_nxt;
    reg [7:0] din_byte_nxt;
    reg din_last_nxt;
    reg done_nxt;
    reg [7:0] status_nxt;
    reg [3:0] sense_key_nxt;
    reg [7:0] asc_nxt;
    reg [7:0] ascq_nxt;
    reg refuse_nxt;
    reg [7:0] data_byte;
    wire [1:0] kind;
    wire [31:0] next_cnt;
    wire [31:0] id_off;
    wire [AW-1:0] id_addr;

    // =========================================
    // Min of two lengths, used for both commands
    function [31:0] min32;
        input [31:0] a;
        input [31:0] b;
        begin
            min32 = (a < b) ? a : b;
        end
    endfunction

    // Which of the two commands a block asks for; anything else is left alone
    function [1:0] cmd_kind;
        input [7:0] op;
        input [4:0] sa;
        begin
            cmd_kind = K_NONE;
            if (op == `RILC_OP_REPORT_ID && sa == `RILC_SA_REPORT_ID)
                cmd_kind = K_ID; // RL1
            else if (op == `RILC_OP_REPORT_LUNS)
                cmd_kind = K_LUNS; // RL10
        end
    endfunction

    // =========================================
    // Submodules
    rilc_cdb_capture u_cap (
        .clk(clk),
        .rst_b(rst_b),
        .cdb_valid(cdb_valid),
        .cdb_byte(cdb_byte),
        .cdb_last(cdb_last),
        .cdb_done(cdb_done),
        .cdb_opcode(cdb_op),
        .cdb_sa(cdb_sa),
        .cdb_lun(cdb_lun),
        .cdb_alloc(cdb_alloc)
    );

    // One store shared by all ports
    rilc_id_store #(.ID_MAX(ID_MAX), .AW(AW)) u_store ( // RL8
        .clk(clk),
        .rst_b(rst_b),
        .ld_valid(ld_valid),
        .ld_addr(ld_addr),
        .ld_byte(ld_byte),
        .ld_commit(ld_commit),
        .ld_len(ld_len),
        .rd_addr(id_addr),
        .rd_byte(id_rd_byte),
        .id_len(id_len)
    );

    // =========================================
    // Byte address into the store; one cycle ahead of the byte it feeds
    assign next_cnt = (din_valid && din_ready) ? cnt_r + 32'h1 : cnt_r;
    assign id_off = next_cnt - `RILC_ID_HDR_BYTES;
    assign id_addr = id_off[AW-1:0];
    assign kind = cmd_kind(cdb_op, cdb_sa);

    // Byte of parameter data at a given offset
    always @* begin
        data_byte = 8'h00;
        if (is_id_r) begin
            case (cnt_r)
                32'h0: data_byte = id_len[31:24]; // RL4 RL5
                32'h1: data_byte = id_len[23:16];
                32'h2: data_byte = id_len[15:8];
                32'h3: data_byte = id_len[7:0];
                default: data_byte = id_rd_byte; // RL4 RL7
            endcase
        end else begin
            // Only byte 3 is nonzero; reserved and entry bytes are zero
            if (cnt_r == 32'h3)
                data_byte = LUN_LIST_LEN[7:0]; // RL14
        end
    end

    // =========================================
    // Pin synchroniser
    always @(posedge clk) begin
        if (!rst_b) begin
            nv_meta_r <= 1'b0;
            nv_sync_r <= 1'b0;
        end else begin
            nv_meta_r <= nv_ready_pin;
            nv_sync_r <= nv_meta_r;
        end
    end

    // =========================================
    // Completion code of a decoded block
    always @* begin
        status_nxt = `RILC_ST_GOOD;
        sense_key_nxt = `RILC_SK_NONE;
        asc_nxt = 8'h00;
        ascq_nxt = `RILC_ASCQ_NONE;
        refuse_nxt = 1'b0;
        case (kind)
            K_ID: begin
                if (cdb_lun != 16'h0000) begin
                    refuse_nxt = 1'b1;
                    status_nxt = `RILC_ST_CHECK; // RL2
                    sense_key_nxt = `RILC_SK_ILLEGAL;
                    asc_nxt = `RILC_ASC_INV_CDB;
                end else if (!nv_sync_r) begin
                    // No wait for the store: fail at once
                    refuse_nxt = 1'b1;
                    status_nxt = `RILC_ST_CHECK; // RL9
                    sense_key_nxt = `RILC_SK_NOT_READY;
                    asc_nxt = `RILC_ASC_NOT_READY;
                    ascq_nxt = `RILC_ASCQ_NOT_READY;
                end
            end
            K_LUNS: begin
                // Reservations play no part in the listing
                if (cdb_alloc < `RILC_LUN_MIN_ALLOC) begin
                    refuse_nxt = 1'b1;
                    status_nxt = `RILC_ST_CHECK; // RL12
                    sense_key_nxt = `RILC_SK_ILLEGAL;
                    asc_nxt = `RILC_ASC_INV_CDB;
                end
            end
            default: refuse_nxt = 1'b0;
        endcase
    end

    // =========================================
    // Completion registers
    // Only a recognised block, refused or not, replaces them, so an ignored one leaves them standing
    always @(posedge clk) begin
        if (!rst_b) begin
            status_r <= `RILC_ST_GOOD;
            sense_key_r <= `RILC_SK_NONE;
            asc_r <= 8'h00;
            ascq_r <= `RILC_ASCQ_NONE;
        end else if (state_r == S_IDLE && cdb_done && kind != K_NONE) begin
            status_r <= status_nxt;
            sense_key_r <= sense_key_nxt;
            asc_r <= asc_nxt;
            ascq_r <= ascq_nxt;
        end
    end

    // =========================================
    // Command sequencer, next values
    always @* begin
        state_nxt = state_r;
        is_id_nxt = is_id_r;
        total_nxt = total_r;
        cnt_nxt = cnt_r;
        din_valid_nxt = din_valid;
        din_byte_nxt = din_byte;
        din_last_nxt = din_last;
        done_nxt = 1'b0;
        case (state_r)
            S_IDLE: begin
                cnt_nxt = 32'h0;
                if (cdb_done && kind != K_NONE) begin // RL11
                    is_id_nxt = (kind == K_ID);
                    state_nxt = S_DONE;
                    if (!refuse_nxt) begin
                        state_nxt = S_PREP;
                        if (kind == K_ID) begin
                            total_nxt = min32(cdb_alloc, id_len + `RILC_ID_HDR_BYTES); // RL3
                        end else begin
                            // Minimum 16 always fits the single entry
                            total_nxt = min32(cdb_alloc, `RILC_LUN_TOTAL); // RL13
                        end
                    end
                end
            end
            S_PREP: begin
                // Extra cycle lets the store read settle
                if (total_r == 32'h0) begin
                    state_nxt = S_DONE;
                end else begin
                    din_valid_nxt = 1'b1; // RL15
                    din_byte_nxt = data_byte;
                    din_last_nxt = (cnt_r == total_r - 32'h1); // RL3 RL13
                    state_nxt = S_SEND;
                end
            end
            S_SEND: begin
                if (din_ready) begin
                    din_valid_nxt = 1'b0;
                    if (din_last) begin
                        din_last_nxt = 1'b0;
                        state_nxt = S_DONE;
                    end else begin
                        cnt_nxt = cnt_r + 32'h1;
                        state_nxt = S_PREP;
                    end
                end
            end
            S_DONE: begin
                done_nxt = 1'b1;
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // =========================================
    // Command sequencer registers
    always @(posedge clk) begin
        if (!rst_b) begin
            state_r <= S_IDLE;
            is_id_r <= 1'b0;
            total_r <= 32'h0;
            cnt_r <= 32'h0;
            din_valid <= 1'b0;
            din_byte <= 8'h00;
            din_last <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            is_id_r <= is_id_nxt;
            total_r <= total_nxt;
            cnt_r <= cnt_nxt;
            din_valid <= din_valid_nxt;
            din_byte <= din_byte_nxt;
            din_last <= din_last_nxt;
            done_r <= done_nxt;
        end
    end

    // Reservation state is only looked at so the port is not left dangling
    wire unused_rsv = rsv_conflict; // RL11
endmodule

// *** rilc_report_cmds_assertions.sv ***
`timescale 1ns/100ps
module rilc_report_cmds_assertions (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Data-in stream
    input wire din_valid,
    input wire [7:0] din_byte,
    input wire din_last,
    input wire din_ready,
    // Completion
    input wire done_r,
    input wire [7:0] status_r,
    input wire [3:0] sense_key_r,
    input wire [7:0] asc_r,
    input wire [7:0] ascq_r
);
    // ==========
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_hold;
        din_valid && !din_ready |=> din_valid && $stable(din_byte) && $stable(din_last);
    endproperty
    a_hold: assert property (p_hold) else $error("byte moved while stalled");
    property p_gap;
        din_valid && din_ready |=> !din_valid;
    endproperty
    a_gap: assert property (p_gap) else $error("no gap after accept");
    property p_next;
        din_valid && din_ready && !din_last |-> ##2 din_valid;
    endproperty
    a_next: assert property (p_next) else $error("stream stopped early");
    property p_end;
        din_valid && din_ready && din_last |-> ##2 done_r && status_r == 8'h00;
    endproperty
    a_end: assert property (p_end) else $error("no good end after data");
    property p_pulse;
        done_r |=> !done_r;
    endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
    property p_ill;
        done_r && sense_key_r == 4'h5 |-> status_r == 8'h02 && asc_r == 8'h24 && ascq_r == 8'h00;
    endproperty
    a_ill: assert property (p_ill) else $error("bad illegal request sense");
    property p_nrdy;
        done_r && sense_key_r == 4'h2 |-> status_r == 8'h02 && asc_r == 8'h04;
    endproperty
    a_nrdy: assert property (p_nrdy) else $error("bad not ready sense");
    property p_quiet;
        din_valid |-> !done_r;
    endproperty
    a_quiet: assert property (p_quiet) else $error("done during data");
    // Reset itself is checked, so this one is never disabled
    property p_rst;
        disable iff (1'b0) !rst_b |=> !din_valid && !done_r && status_r == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind rilc_report_cmds rilc_report_cmds_assertions i_chk (.clk, .rst_b, .din_valid, .din_byte,
    .din_last, .din_ready, .done_r, .status_r, .sense_key_r, .asc_r, .ascq_r);

// *** rilc_init_model.sv ***
`timescale 1ns/100ps
module rilc_init_model (
    // Clock
    input wire clk,
    // Command bytes
    output logic cdb_valid,
    output logic [7:0] cdb_byte,
    output logic cdb_last,
    // Data-in stream
    input wire din_valid,
    input wire [7:0] din_byte,
    input wire din_last,
    output logic din_ready
);
    logic slow = 1'b0;
    logic tog = 1'b0;
    logic [7:0] rx [0:255];
    int rx_n = 0;
    int last_n = 0;
    initial begin
        cdb_valid = 1'b0;
        cdb_byte = 8'h00;
        cdb_last = 1'b0;
    end
    // Slow mode stalls every other cycle
    assign din_ready = slow ? tog : 1'b1;
    always @(posedge clk) begin
        tog <= ~tog;
        if (din_valid && din_ready) begin
            rx[rx_n[7:0]] <= din_byte;
            rx_n <= rx_n + 1;
            if (din_last) begin
                last_n <= rx_n + 1;
            end
        end
    end
    // Caller keeps lun zero and listing alloc at least 16 unless refusal is wanted
    task automatic send(input logic [7:0] op, input logic [4:0] sa, input logic [15:0] lun,
                        input logic [31:0] al);
        logic [7:0] b [0:11];
        b = '{op, {3'h0, sa}, 8'h00, 8'h00, lun[15:8], lun[7:0], al[31:24], al[23:16],
              al[15:8], al[7:0], 8'h00, 8'h00};
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            cdb_valid <= 1'b1;
            cdb_byte <= b[i];
            cdb_last <= (i == 11);
        end
        @(posedge clk);
        cdb_valid <= 1'b0;
        cdb_last <= 1'b0;
        // Idle byte is inverted so a stale value is never seen as valid
        cdb_byte <= ~b[11];
    endtask
endmodule

// *** rilc_report_cmds_tb.sv ***
`timescale 1ns/100ps
module rilc_report_cmds_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic rsv_conflict = 1'b0;
    logic nv_ready_pin = 1'b1;
    logic ld_valid = 1'b0;
    logic [5:0] ld_addr = 6'h00;
    logic [7:0] ld_byte = 8'h00;
    logic ld_commit = 1'b0;
    logic [31:0] ld_len = 32'h0;
    wire cdb_valid, cdb_last, din_valid, din_last, din_ready, done_r;
    wire [7:0] cdb_byte, din_byte, status_r, asc_r, ascq_r;
    wire [3:0] sense_key_r;
    int error_cnt = 0;
    int checks_done = 0;
    logic [7:0] exp_q [$];
    initial begin
        forever #2 clk = ~clk;
    end
    rilc_report_cmds i_dut (.clk, .rst_b, .cdb_valid, .cdb_byte, .cdb_last, .rsv_conflict,
        .nv_ready_pin, .ld_valid, .ld_addr, .ld_byte, .ld_commit, .ld_len, .din_valid,
        .din_byte, .din_last, .din_ready, .done_r, .status_r, .sense_key_r, .asc_r, .ascq_r);
    rilc_init_model i_init (.clk, .cdb_valid, .cdb_byte, .cdb_last, .din_valid, .din_byte,
        .din_last, .din_ready);
    // ==========
    // Helpers
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic load(input int n, input logic [31:0] len);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            ld_valid <= 1'b1;
            ld_addr <= i[5:0];
            ld_byte <= 8'h11 * (i[7:0] + 8'h01);
        end
        @(posedge clk);
        ld_valid <= 1'b0;
        ld_commit <= 1'b1;
        ld_len <= len;
        @(posedge clk);
        ld_commit <= 1'b0;
    endtask
    task automatic run(input logic [7:0] op, input logic [4:0] sa, input logic [15:0] lun,
                       input logic [31:0] al, input logic [7:0] st, input logic [3:0] sk,
                       input logic [7:0] asc);
        int n;
        n = 0;
        i_init.rx_n = 0;
        i_init.last_n = 0;
        i_init.send(op, sa, lun, al);
        while (n < 400 && done_r !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        cmp("done", 1, n < 400);
        cmp("status", st, status_r);
        cmp("sense", sk, sense_key_r);
        cmp("asc", asc, asc_r);
        cmp("ascq", 0, ascq_r);
        cmp("count", exp_q.size(), i_init.rx_n);
        cmp("last", exp_q.size(), i_init.last_n);
        foreach (exp_q[i]) cmp("byte", exp_q[i], i_init.rx[i]);
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    // ==========
    // Scenarios
    task automatic t_ident;
        exp_q = '{0, 0, 0, 0};
        run(8'ha3, 5'h05, 16'h0, 32'h40, 8'h00, 4'h0, 8'h00);
        load(5, 5);
        @(posedge clk);
        i_init.slow <= 1'b1;
        exp_q = '{0, 0, 0, 5, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        run(8'ha3, 5'h05, 16'h0, 32'h100, 8'h00, 4'h0, 8'h00);
        exp_q = '{0, 0, 0, 5, 8'h11, 8'h22};
        run(8'ha3, 5'h05, 16'h0, 32'h6, 8'h00, 4'h0, 8'h00);
        @(posedge clk);
        i_init.slow <= 1'b0;
        exp_q = {};
        run(8'ha3, 5'h05, 16'h0, 32'h0, 8'h00, 4'h0, 8'h00);
        do_reset();
        exp_q = '{0, 0, 0, 0};
        run(8'ha3, 5'h05, 16'h0, 32'h40, 8'h00, 4'h0, 8'h00);
        load(0, 3);
        exp_q = '{0, 0, 0, 3, 8'h11, 8'h22, 8'h33};
        run(8'ha3, 5'h05, 16'h0, 32'h40, 8'h00, 4'h0, 8'h00);
        $display("test ident done");
    endtask
    task automatic t_errors;
        int n;
        exp_q = {};
        run(8'ha3, 5'h05, 16'h0100, 32'h40, 8'h02, 4'h5, 8'h24);
        @(posedge clk);
        nv_ready_pin <= 1'b0;
        repeat (3) @(posedge clk);
        run(8'ha3, 5'h05, 16'h0, 32'h40, 8'h02, 4'h2, 8'h04);
        @(posedge clk);
        nv_ready_pin <= 1'b1;
        repeat (3) @(posedge clk);
        // Unsupported blocks belong elsewhere and must stay silent
        n = 0;
        i_init.send(8'ha3, 5'h0c, 16'h0, 32'h40);
        repeat (40) begin
            @(negedge clk);
            if (done_r !== 1'b0) n++;
        end
        cmp("ignored", 0, n);
        cmp("held status", 8'h02, status_r);
        cmp("silent data", 0, i_init.rx_n);
        $display("test errors done");
    endtask
    task automatic t_luns;
        @(posedge clk);
        rsv_conflict <= 1'b1;
        exp_q = '{0, 0, 0, 8, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
        run(8'ha0, 5'h00, 16'h0, 32'h10, 8'h00, 4'h0, 8'h00);
        @(posedge clk);
        i_init.slow <= 1'b1;
        run(8'ha0, 5'h00, 16'h0, 32'h1000, 8'h00, 4'h0, 8'h00);
        @(posedge clk);
        i_init.slow <= 1'b0;
        exp_q = {};
        run(8'ha0, 5'h00, 16'h0, 32'hf, 8'h02, 4'h5, 8'h24);
        $display("test luns done");
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Generous margin over the few hundred cycles the tests need
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_ident();
        t_errors();
        t_luns();
        test_done();
    end
endmodule
